//--- core/pmtr_pkg.sv
// shared constants for the program memory table reader
package pmtr_pkg;
    localparam int          PMTR_WORD_W      = 16;
    localparam int          PMTR_DEPTH_4K    = 4096;
    localparam int          PMTR_DEPTH_8K    = 8192;
    localparam logic [15:0] PMTR_RESET_VEC   = 16'h0000;
    localparam logic [7:0]  PMTR_TABLE_HIGH_BYTE_LATCH_RST    = 8'h00;
    localparam logic [7:0]  PMTR_SECTOR0     = 8'h00;
    localparam logic [1:0]  PMTR_OP_SHORT    = 2'h0;
    localparam logic [1:0]  PMTR_OP_EXT      = 2'h1;
    localparam int          PMTR_SYNC_STAGES = 2;
endpackage

//--- core/pmtr_table_reader.sv
// table read engine and program counter fetch port for the flash program array
`timescale 1ns/1ps
module pmtr_table_reader
    import pmtr_pkg::*;
#(
    parameter int WORD_W = PMTR_WORD_W,
    parameter int DEPTH  = PMTR_DEPTH_8K,
    parameter int IMPL_W = 16
) (
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire logic                     cycle_en,
    input  wire logic                     emulation_variant,
    input  wire logic                     table_read_req,
    input  wire logic [1:0]               table_read_kind,
    input  wire logic [7:0]               table_ptr_low,
    input  wire logic [7:0]               table_ptr_high,
    input  wire logic [7:0]               dest_sector,
    input  wire logic [7:0]               dest_addr,
    input  wire logic                     pc_load,
    input  wire logic [$clog2(DEPTH)-1:0] pc_load_value,
    input  wire logic                     table_high_byte_latch_wr,
    input  wire logic [7:0]               table_high_byte_latch_wdata,
    output logic [$clog2(DEPTH)-1:0]      pm_addr,
    output logic                          pm_rd,
    input  wire logic [WORD_W-1:0]        pm_rdata,
    output logic [$clog2(DEPTH)-1:0]      pc,
    output logic                          fetch_valid,
    output logic                          dm_wr,
    output logic [7:0]                    dm_wsector,
    output logic [7:0]                    dm_waddr,
    output logic [7:0]                    dm_wdata,
    output logic [7:0]                    table_high_byte_latch,
    output logic                          table_busy,
    output logic                          table_read_refused,
    input  wire logic                     program_serial_clock_line,
    input  wire logic                     program_serial_data_line_in,
    input  wire logic                     prog_data_drive,
    input  wire logic                     prog_data_bit,
    output logic                          program_serial_data_line_out,
    output logic                          program_serial_data_line_oe,
    output logic                          prog_clock_sync,
    output logic                          prog_data_sync,
    input  wire logic                     debug_serial_clock_line,
    input  wire logic                     debug_serial_data_line_in,
    output logic                          debug_clock_sync,
    output logic                          debug_data_sync
);
    localparam int AW = $clog2(DEPTH);

    // timing, counted in instruction cycles (cycle_en pulses):
    //   take edge  - pointer and destination captured, busy set, fetch held
    //   data edge  - low byte written, high byte latched, busy cleared
    //   the fetch address returns to the memory port one clock later
    // requests seen while busy are dropped, not queued; the decoder
    // must not present a new table read until busy has fallen
    // pm_rdata is expected to settle within one instruction cycle
    // of the address change, which the four clock cycle spacing allows

    // the fetch and mask logic only serve a 16 bit word
    if (WORD_W != 16) begin : g_bad_word
        $error("pmtr_table_reader: word width must be 16");
    end

    // only the two array depths of the family are decoded
    if (DEPTH != PMTR_DEPTH_4K && DEPTH != PMTR_DEPTH_8K) begin : g_bad_depth
        $error("pmtr_table_reader: depth must be 4096 or 8192");
    end

    // at least one high bit must exist, at most the full byte
    if (IMPL_W < 9 || IMPL_W > WORD_W) begin : g_bad_impl
        $error("pmtr_table_reader: implemented width out of range");
    end

    // idle waits for a take; data owns the memory port for one cycle
    typedef enum logic [1:0] {
        PMTR_IDLE = 2'b01,
        PMTR_DATA = 2'b10
    } pmtr_state_t;

    pmtr_state_t       state_q;
    // request captured at the take edge
    logic [AW-1:0]     tbl_addr_q;
    logic [7:0]        dst_sector_q;
    logic [7:0]        dst_addr_q;
    logic [7:0]        hi_mask;
    logic [15:0]       full_ptr;
    logic              legal_req;
    // pin synchroniser stages
    logic [3:0]        sync1_q;
    logic [3:0]        sync2_q;
    logic [3:0]        pin_raw;

    // unimplemented high bits forced low when a table read loads the latch; software writes are not masked
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            hi_mask[i] = (i + 8) < IMPL_W;
        end
    end

    assign full_ptr = {table_ptr_high, table_ptr_low};
    // short form only legal when destination sits in sector 0
    assign legal_req = table_read_req && !table_busy &&
                       (table_read_kind == PMTR_OP_EXT ||
                        dest_sector == PMTR_SECTOR0);

    // sequencer: one instruction cycle to take, one for the data access
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PMTR_IDLE;
        end else if (cycle_en) begin
            unique case (state_q)
                PMTR_IDLE: begin
                    if (legal_req) begin
                        state_q <= PMTR_DATA;
                    end
                end
                PMTR_DATA: begin
                    state_q <= PMTR_IDLE;
                end
            endcase
        end
    end

    // busy is a flop of its own so the decoder sees it glitch free
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            table_busy <= 1'b0;
        end else if (cycle_en) begin
            table_busy <= (state_q == PMTR_IDLE) && legal_req;
        end
    end

    // pointer and destination captured at the take edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tbl_addr_q   <= '0;
            dst_sector_q <= 8'h00;
            dst_addr_q   <= 8'h00;
        end else if (cycle_en && state_q == PMTR_IDLE && legal_req) begin
            tbl_addr_q   <= full_ptr[AW-1:0];
            dst_sector_q <= dest_sector;
            dst_addr_q   <= dest_addr;
        end
    end

    // refused stands for one instruction cycle only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            table_read_refused <= 1'b0;
        end else if (cycle_en) begin
            table_read_refused <= table_read_req && !table_busy && !legal_req;
        end
    end

    // program counter; stalls while the data access owns the port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc <= PMTR_RESET_VEC[AW-1:0];
        end else if (cycle_en) begin
            if (pc_load) begin
                pc <= pc_load_value;
            end else if (state_q == PMTR_IDLE && !legal_req) begin
                pc <= pc + 1'b1;
            end
        end
    end

    // fetch marker stays low for both cycles of a table read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fetch_valid <= 1'b0;
        end else if (cycle_en) begin
            fetch_valid <= !pc_load && state_q == PMTR_IDLE && !legal_req;
        end
    end

    // the array is read on every clock once out of reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pm_rd <= 1'b0;
        end else begin
            pm_rd <= 1'b1;
        end
    end

    // memory port: data address from a legal request in idle through the second cycle, else the fetch address
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pm_addr <= PMTR_RESET_VEC[AW-1:0];
        end else if (state_q == PMTR_IDLE && legal_req) begin
            pm_addr <= full_ptr[AW-1:0];
        end else if (state_q == PMTR_IDLE) begin
            pm_addr <= pc;
        end else begin
            pm_addr <= tbl_addr_q;
        end
    end

    // write strobe lasts one clock at the end of the second cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dm_wr <= 1'b0;
        end else begin
            dm_wr <= cycle_en && state_q == PMTR_DATA;
        end
    end

    // data and destination stand until the next table read lands
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dm_wsector <= 8'h00;
            dm_waddr   <= 8'h00;
            dm_wdata   <= 8'h00;
        end else if (cycle_en && state_q == PMTR_DATA) begin
            dm_wsector <= dst_sector_q;
            dm_waddr   <= dst_addr_q;
            dm_wdata   <= pm_rdata[7:0];
        end
    end

    // hardware load wins over a simultaneous software write;
    // software saves and restores it around an interrupt routine
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            table_high_byte_latch <= PMTR_TABLE_HIGH_BYTE_LATCH_RST;
        end else if (cycle_en && state_q == PMTR_DATA) begin
            table_high_byte_latch <= pm_rdata[15:8] & hi_mask;
        end else if (table_high_byte_latch_wr) begin
            table_high_byte_latch <= table_high_byte_latch_wdata;
        end
    end

    // raw pins in a fixed order: prog clk, prog data, debug clk, debug data
    assign pin_raw = {debug_serial_data_line_in, debug_serial_clock_line,
                      program_serial_data_line_in, program_serial_clock_line};

    // two flops per pin; only the second stage is read by later logic
    for (genvar p = 0; p < 4; p++) begin : g_sync
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                sync1_q[p] <= 1'b0;
                sync2_q[p] <= 1'b0;
            end else begin
                sync1_q[p] <= pin_raw[p];
                sync2_q[p] <= sync1_q[p];
            end
        end
    end

    // programming pins stay live on both variants
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prog_clock_sync <= 1'b0;
            prog_data_sync  <= 1'b0;
        end else begin
            prog_clock_sync <= sync2_q[0];
            prog_data_sync  <= sync2_q[1];
        end
    end

    // one line carries both directions; oe high only while we drive it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            program_serial_data_line_out <= 1'b0;
            program_serial_data_line_oe  <= 1'b0;
        end else begin
            program_serial_data_line_out <= prog_data_bit;
            program_serial_data_line_oe  <= prog_data_drive;
        end
    end

    // debug functions idle on the emulation part; the pins still program
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            debug_clock_sync <= 1'b0;
            debug_data_sync  <= 1'b0;
        end else begin
            debug_clock_sync <= emulation_variant ? 1'b0 : sync2_q[2];
            debug_data_sync  <= emulation_variant ? 1'b0 : sync2_q[3];
        end
    end
endmodule

//--- tb/pmtr_table_reader_assertions.sv
// port-level checks for the table reader
`timescale 1ns/1ps
module pmtr_table_reader_assertions
    import pmtr_pkg::*;
#(
    parameter int DEPTH = PMTR_DEPTH_8K
) (
    input wire logic                     clock,
    input wire logic                     rst_n,
    input wire logic                     cycle_en,
    input wire logic                     emulation_variant,
    input wire logic                     table_read_req,
    input wire logic [1:0]               table_read_kind,
    input wire logic [7:0]               dest_sector,
    input wire logic                     pc_load,
    input wire logic [$clog2(DEPTH)-1:0] pc,
    input wire logic                     dm_wr,
    input wire logic                     table_busy,
    input wire logic                     table_read_refused,
    input wire logic                     debug_clock_sync,
    input wire logic                     debug_data_sync
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic start;
    logic legal;
    assign start = cycle_en && !table_busy && table_read_req;
    assign legal = table_read_kind == PMTR_OP_EXT || dest_sector == PMTR_SECTOR0;
    a_take_busy: assert property (start && legal |=> table_busy)
        else $error("busy missing after take");
    a_short_refused: assert property (start && !legal |=> table_read_refused && !table_busy)
        else $error("short read outside sector 0 taken");
    a_refuse_holds: assert property (table_read_refused && !cycle_en |=> table_read_refused)
        else $error("refused flag dropped early");
    a_answer_write: assert property (table_busy && cycle_en |=> dm_wr && !table_busy)
        else $error("no write at second cycle");
    a_write_pulse: assert property (dm_wr |=> !dm_wr)
        else $error("write strobe too long");
    a_pc_held: assert property (table_busy && !$past(pc_load) |-> $stable(pc))
        else $error("fetch advanced during table cycle");
    a_reset_vector: assert property (!$past(rst_n) |-> pc == '0)
        else $error("pc not zero after reset");
    a_emul_quiet: assert property (emulation_variant [*3] |-> !debug_clock_sync && !debug_data_sync)
        else $error("debug pins active on emulation part");
    c_take: cover property (start && legal);
    c_refuse: cover property (start && !legal);
    c_emul: cover property (emulation_variant && cycle_en);
endmodule

//--- tb/pmtr_flash_model.sv
// flash program array model
`timescale 1ns/1ps
module pmtr_flash_model #(
    parameter int AW = 13
) (
    input  wire logic [AW-1:0] pm_addr,
    input  wire logic          pm_rd,
    output logic [15:0]        pm_rdata
);
    // word carries its own address; unused top bits set so masking is seen
    assign pm_rdata = pm_rd ? {{(16-AW){1'h1}}, pm_addr} : {{(16-AW){1'h0}}, ~pm_addr};
endmodule

//--- tb/tb_pmtr_table_reader.sv
// self-checking bench for the table reader
`timescale 1ns/1ps
module tb_pmtr_table_reader import pmtr_pkg::*;;
    localparam int DEPTH = PMTR_DEPTH_8K;
    localparam int AW = $clog2(DEPTH);
    logic clock, rst_n, cycle_en, emulation_variant, table_read_req, pc_load, table_high_byte_latch_wr, host_bit;
    logic program_serial_clock_line, program_serial_data_line_in, prog_data_drive, prog_data_bit;
    logic debug_serial_clock_line, debug_serial_data_line_in, pm_rd, fetch_valid, dm_wr, table_busy;
    logic table_read_refused, program_serial_data_line_out, program_serial_data_line_oe;
    logic prog_clock_sync, prog_data_sync, debug_clock_sync, debug_data_sync;
    logic [1:0] table_read_kind, ce_cnt;
    logic [7:0] table_ptr_low, table_ptr_high, dest_sector, dest_addr, table_high_byte_latch_wdata;
    logic [7:0] dm_wsector, dm_waddr, dm_wdata, table_high_byte_latch;
    logic [AW-1:0] pc_load_value, pm_addr, pc;
    logic [15:0] pm_rdata;
    int error_cnt, checked, cycles;
    // implemented high byte is 5 bits so the top three must come back zero
    pmtr_table_reader #(.DEPTH(DEPTH), .IMPL_W(13)) u_pmtr_table_reader (.*);
    pmtr_flash_model #(.AW(AW)) u_pmtr_flash_model (.*);
    assign program_serial_data_line_in = program_serial_data_line_oe ? program_serial_data_line_out : host_bit;
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        ce_cnt <= ce_cnt + 2'h1;
        cycle_en <= ce_cnt == 2'h3 && rst_n;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wait_ce;
        do @(posedge clock); while (cycle_en !== 1'h1);
    endtask
    // called just after an instruction cycle edge, so reads run back to back
    task t_read(input logic [1:0] k, input logic [7:0] sec, input logic [7:0] lo, input logic [7:0] hi);
        logic [AW-1:0] pc0;
        table_read_req <= 1'h1;
        table_read_kind <= k;
        dest_sector <= sec;
        dest_addr <= lo ^ 8'h3C;
        table_ptr_low <= lo;
        table_ptr_high <= hi;
        wait_ce;
        table_read_req <= 1'h0;
        #1 chk("busy", 16'h1, table_busy);
        chk("pm_addr", {3'h0, hi[4:0], lo}, pm_addr);
        chk("fetch_hold", 16'h0, fetch_valid);
        pc0 = pc;
        wait_ce;
        #1 chk("dm_wr", 16'h1, dm_wr);
        chk("pc_held", {3'h0, pc0}, pc);
        chk("dm_wdata", lo, dm_wdata);
        chk("dest", {sec, lo ^ 8'h3C}, {dm_wsector, dm_waddr});
        chk("latch", {3'h0, hi[4:0]}, table_high_byte_latch);
        chk("busy_end", 16'h0, table_busy);
    endtask
    task t_refuse;
        table_read_req <= 1'h1;
        table_read_kind <= PMTR_OP_SHORT;
        dest_sector <= 8'h02;
        wait_ce;
        table_read_req <= 1'h0;
        #1 chk("refused", 16'h2, {table_read_refused, table_busy});
        wait_ce;
        #1 chk("latch_kept", 16'h0C, table_high_byte_latch);
        chk("fetch_run", 16'h1, fetch_valid);
    endtask
    // interrupt routine read with the latch saved and put back around it
    task t_isr_save;
        logic [7:0] saved;
        saved = table_high_byte_latch;
        t_read(PMTR_OP_SHORT, 8'h00, 8'h01, 8'h15);
        table_high_byte_latch_wr <= 1'h1;
        table_high_byte_latch_wdata <= saved;
        @(posedge clock);
        table_high_byte_latch_wr <= 1'h0;
        #1 chk("latch_restored", {8'h0, saved}, table_high_byte_latch);
    endtask
    task t_table_high_byte_latch;
        @(posedge clock);
        table_high_byte_latch_wr <= 1'h1;
        table_high_byte_latch_wdata <= 8'h5A;
        @(posedge clock);
        table_high_byte_latch_wr <= 1'h0;
        #1 chk("latch_sw", 16'h5A, table_high_byte_latch);
    endtask
    task t_pins(input logic emu, input logic drv);
        emulation_variant <= emu;
        prog_data_drive <= drv;
        prog_data_bit <= drv;
        host_bit <= 1'h0;
        program_serial_clock_line <= drv;
        debug_serial_clock_line <= 1'h1;
        debug_serial_data_line_in <= 1'h1;
        repeat (5) @(posedge clock);
        #1 chk("debug", {14'h0, {2{!emu}}}, {debug_clock_sync, debug_data_sync});
        chk("prog", {13'h0, {3{drv}}}, {program_serial_data_line_oe, prog_clock_sync, prog_data_sync});
    endtask
    task report_and_stop;
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {rst_n, emulation_variant, table_read_req, pc_load, table_high_byte_latch_wr, host_bit} = '0;
        {program_serial_clock_line, prog_data_drive, prog_data_bit, debug_serial_clock_line} = '0;
        {table_read_kind, ce_cnt, table_ptr_low, table_ptr_high, dest_sector, dest_addr} = '0;
        {cycle_en, debug_serial_data_line_in, table_high_byte_latch_wdata, pc_load_value} = '0;
        {error_cnt, checked, cycles} = '0;
        repeat (5) @(posedge clock);
        rst_n <= 1'h1;
        #1 chk("pc_reset", PMTR_RESET_VEC, pc);
        wait_ce;
        t_read(PMTR_OP_SHORT, 8'h00, 8'h06, 8'h1F);
        t_read(PMTR_OP_SHORT, 8'h00, 8'h05, 8'hFF);
        t_read(PMTR_OP_EXT, 8'h03, 8'hA7, 8'h0C);
        t_isr_save;
        t_refuse;
        t_table_high_byte_latch;
        t_pins(1'h0, 1'h1);
        t_pins(1'h1, 1'h0);
        report_and_stop;
    end
endmodule
bind pmtr_table_reader pmtr_table_reader_assertions #(.DEPTH(DEPTH)) u_pmtr_table_reader_assertions (.*);
